// File: scs_clock_select.sv
// system clock source selector: wakeup, prescaled oscillator, digital pll,
// direct pin; glitch-free switching except when leaving the pll, whose high phase is cut short; axi4-lite register slave.
// clock pins are sampled levels, far slower than clk; sys_clk is a registered level.
`timescale 1ns/100ps
module scs_clock_select (
	input wire logic clk, // 250 MHz fabric clock
	input wire logic reset, // async, active high
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic crystal_input_pin, // oscillator level
	input wire logic onchip_clk_in, // on-chip clock source level
	input wire logic direct_clock_pin, // direct drive clock level
	input wire logic wakeup_clk_in, // wakeup oscillator level
	output logic sys_clk, // generated system clock
	input wire logic [4:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte lanes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [4:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready // read data ready
);
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// registers
	logic [1:0] sys_cfg_reg;
	logic [22:0] pll_cfg_reg;
	logic [9:0] presc_reg;
	// bus state
	logic [4:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	// sampled pins
	logic osc_reg, osc_prev_reg, direct_reg, wake_reg;
	// prescaler
	logic [9:0] presc_cnt_reg;
	logic presc_clk_reg;
	// pll
	logic [15:0] tcnt_reg, tmeas_reg, tused_reg;
	logic [27:0] acc_reg;
	logic pll_clk_reg;
	// switch
	scs_pkg::scs_sw_type st_reg;
	logic [1:0] route_reg;
	logic sys_clk_reg;

	// field decode
	wire bypass = pll_cfg_reg[scs_pkg::PLL_BYPASS_BIT];
	wire ref_sel = pll_cfg_reg[scs_pkg::PLL_REFSEL_BIT];
	wire [1:0] band = pll_cfg_reg[scs_pkg::PLL_BAND_LSB +: 2];
	wire [4:0] p_fac = {1'b0, pll_cfg_reg[scs_pkg::PLL_INPUT_DIV_FIELD_LSB +: 4]} + 5'h01;
	wire [7:0] n_fac = {1'b0, pll_cfg_reg[scs_pkg::PLL_FEEDBACK_MULT_FIELD_LSB +: 7]} + 8'h01;
	wire [7:0] k2_fac = {1'b0, pll_cfg_reg[scs_pkg::PLL_OUTPUT_DIV_FIELD_LSB +: 7]} + 8'h01;
	wire [10:0] presc_fac = {1'b0, presc_reg} + 11'h001;
	wire [9:0] presc_half = presc_fac[10:1];

	// route from configuration
	wire [1:0] target_route = (sys_cfg_reg == scs_pkg::SRC_DIRECT) ? scs_pkg::ROUTE_DIRECT :
		(sys_cfg_reg != scs_pkg::SRC_OSC) ? scs_pkg::ROUTE_WAKE :
		bypass ? scs_pkg::ROUTE_PRESC : scs_pkg::ROUTE_PLL;
	wire pll_en = (sys_cfg_reg == scs_pkg::SRC_OSC) && !bypass;

	// oscillator edges and prescaler
	wire osc_rise = osc_reg && !osc_prev_reg;
	wire [9:0] presc_cnt_next = (presc_cnt_reg >= presc_reg) ? 10'h000 : presc_cnt_reg + 10'h001;
	wire presc_clk_next = (presc_reg == 10'h000) ? osc_reg :
		osc_rise ? (presc_cnt_next < presc_half) : presc_clk_reg;

	// pll: reference period tracked one cycle per edge, then a rate accumulator
	wire [15:0] tcnt_inc = (tcnt_reg == 16'hffff) ? tcnt_reg : tcnt_reg + 16'h0001;
	wire [15:0] tused_next = (tused_reg < tmeas_reg) ? tused_reg + 16'h0001 :
		(tused_reg > tmeas_reg) ? tused_reg - 16'h0001 : tused_reg;
	wire [27:0] thr = 28'(tused_reg) * 28'(p_fac) * 28'(k2_fac);
	wire [27:0] acc_sum = acc_reg + {19'h0, n_fac, 1'b0};
	wire pll_toggle = pll_en && (acc_sum >= thr);
	wire pll_locked = pll_en && (tused_reg == tmeas_reg);
	// f_vco = 250 * N / (T * P) MHz, compared without a divider
	// operands widened first, a self-sized product would wrap at 16 bits
	wire [27:0] ref_prod = 28'(tused_reg) * 28'(p_fac);
	wire [35:0] vco_num = 36'(scs_pkg::CLK_MHZ) * 36'(n_fac);
	wire [7:0] band_lo = band[0] ? scs_pkg::BAND1_LO_MHZ : scs_pkg::BAND0_LO_MHZ;
	wire [7:0] band_hi = band[0] ? scs_pkg::BAND1_HI_MHZ : scs_pkg::BAND0_HI_MHZ;
	wire vco_in_range = (36'(band_lo) * 36'(ref_prod) <= vco_num)
		&& (vco_num <= 36'(band_hi) * 36'(ref_prod)) && !band[1];

	// candidate clocks indexed by route
	wire [3:0] cand = {direct_reg, pll_clk_reg, presc_clk_reg, wake_reg};
	wire cur_clk = cand[route_reg];

	// bus decode
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire wr_map = awaddr_reg <= scs_pkg::ADDR_PRESC;
	wire rd_map = s_axi_araddr <= scs_pkg::ADDR_STATUS;
	wire [31:0] status_word = {27'h0, vco_in_range, pll_locked,
		st_reg != scs_pkg::SW_RUN, route_reg};
	wire [31:0] rd_word = (s_axi_araddr == scs_pkg::ADDR_SYS_CFG) ? {30'h0, sys_cfg_reg} :
		(s_axi_araddr == scs_pkg::ADDR_PLL_CFG) ? {9'h0, pll_cfg_reg} :
		(s_axi_araddr == scs_pkg::ADDR_PRESC) ? {22'h0, presc_reg} :
		(s_axi_araddr == scs_pkg::ADDR_STATUS) ? status_word : 32'h0;
	// write targets take effect in one step; ordering is software's concern
	wire [31:0] sys_cfg_wr = merge({30'h0, sys_cfg_reg}, wdata_reg, wstrb_reg);
	wire [31:0] pll_cfg_wr = merge({9'h0, pll_cfg_reg}, wdata_reg, wstrb_reg);
	wire [31:0] presc_wr = merge({22'h0, presc_reg}, wdata_reg, wstrb_reg);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			awaddr_reg <= 5'h00;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
		end else if (ce) begin
			if (aw_take) begin
				s_axi_awready <= 1'b0;
				awaddr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				s_axi_wready <= 1'b0;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sys_cfg_reg <= scs_pkg::SYS_CFG_RESET;
			pll_cfg_reg <= scs_pkg::PLL_CFG_RESET;
			presc_reg <= scs_pkg::PRESC_RESET;
		end else if (ce && wr_go) begin
			if (awaddr_reg == scs_pkg::ADDR_SYS_CFG) begin
				sys_cfg_reg <= sys_cfg_wr[1:0];
			end
			if (awaddr_reg == scs_pkg::ADDR_PLL_CFG) begin
				pll_cfg_reg <= pll_cfg_wr[22:0];
			end
			if (awaddr_reg == scs_pkg::ADDR_PRESC) begin
				presc_reg <= presc_wr[9:0];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (ce) begin
			if (ar_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_map ? 2'h0 : 2'h2;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// pin sampling and prescaler
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			osc_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
			direct_reg <= 1'b0;
			wake_reg <= 1'b0;
			presc_cnt_reg <= 10'h000;
			presc_clk_reg <= 1'b0;
		end else if (ce) begin
			osc_reg <= ref_sel ? onchip_clk_in : crystal_input_pin;
			osc_prev_reg <= osc_reg;
			direct_reg <= direct_clock_pin;
			wake_reg <= wakeup_clk_in;
			presc_clk_reg <= presc_clk_next;
			if (osc_rise) begin
				presc_cnt_reg <= presc_cnt_next;
			end
		end
	end

	// pll; frozen at zero phase while not selected
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tcnt_reg <= 16'h0000;
			tmeas_reg <= scs_pkg::PERIOD_RESET;
			tused_reg <= scs_pkg::PERIOD_RESET;
			acc_reg <= 28'h0;
			pll_clk_reg <= 1'b0;
		end else if (ce) begin
			tcnt_reg <= osc_rise ? 16'h0000 : tcnt_inc;
			if (osc_rise) begin
				tmeas_reg <= tcnt_inc;
				tused_reg <= tused_next;
			end
			if (!pll_en) begin
				acc_reg <= 28'h0;
				pll_clk_reg <= 1'b0;
			end else if (pll_toggle) begin
				acc_reg <= acc_sum - thr;
				pll_clk_reg <= !pll_clk_reg;
			end else begin
				acc_reg <= acc_sum;
			end
		end
	end

	// glitch-free switch: finish old high phase, then wait for new source low
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_reg <= scs_pkg::SW_RUN;
			route_reg <= scs_pkg::ROUTE_WAKE;
			sys_clk_reg <= 1'b0;
		end else if (ce) begin
			case (st_reg)
				scs_pkg::SW_RUN: begin
					sys_clk_reg <= cur_clk;
					if (target_route != route_reg) begin
						st_reg <= scs_pkg::SW_DRAIN;
					end
				end
				scs_pkg::SW_DRAIN: begin
					sys_clk_reg <= cur_clk && sys_clk_reg; // no new high phase of old
					if (!cur_clk) begin
						route_reg <= target_route;
						st_reg <= scs_pkg::SW_WAIT;
					end
				end
				scs_pkg::SW_WAIT: begin
					sys_clk_reg <= 1'b0;
					if (!cur_clk) begin
						st_reg <= scs_pkg::SW_RUN;
					end
				end
				default: begin
					st_reg <= scs_pkg::SW_RUN;
				end
			endcase
		end
	end

	assign sys_clk = sys_clk_reg;

	// checks
	chk_direct_pass: assert property (@(posedge clk) disable iff (reset)
		(ce && st_reg == scs_pkg::SW_RUN && route_reg == scs_pkg::ROUTE_DIRECT)
		|=> sys_clk_reg == $past(direct_reg))
		else $error("direct clock not passed through");
	chk_presc_route: assert property (@(posedge clk) disable iff (reset)
		(ce && st_reg == scs_pkg::SW_RUN && route_reg == scs_pkg::ROUTE_PRESC)
		|=> sys_clk_reg == $past(presc_clk_reg))
		else $error("prescaled clock not routed");
	chk_presc_wrap: assert property (@(posedge clk) disable iff (reset)
		(ce && osc_rise && presc_cnt_reg == presc_reg) |=> presc_cnt_reg == 10'h000)
		else $error("prescaler count does not wrap at field value");
	chk_presc_limit: assert property (@(posedge clk) disable iff (reset)
		presc_fac <= scs_pkg::PRESC_MAX_FACTOR && presc_fac != 11'h000)
		else $error("prescaler factor out of range");
	chk_unity_follow: assert property (@(posedge clk) disable iff (reset)
		(ce && presc_reg == 10'h000) |=> presc_clk_reg == $past(osc_reg))
		else $error("unity prescaler does not follow oscillator");
	chk_pll_idle: assert property (@(posedge clk) disable iff (reset)
		(ce && !pll_en) |=> (acc_reg == 28'h0 && !pll_clk_reg))
		else $error("pll runs while not selected");
	chk_pll_toggle: assert property (@(posedge clk) disable iff (reset)
		(ce && pll_en && acc_sum >= thr) |=> pll_clk_reg != $past(pll_clk_reg))
		else $error("pll missed a toggle");
	chk_ref_select: assert property (@(posedge clk) disable iff (reset)
		ce |=> osc_reg == ($past(ref_sel) ? $past(onchip_clk_in) : $past(crystal_input_pin)))
		else $error("wrong reference selected");
	chk_period_slew: assert property (@(posedge clk) disable iff (reset)
		ce |=> (tused_reg - $past(tused_reg) <= 16'h0001
			|| $past(tused_reg) - tused_reg <= 16'h0001))
		else $error("pll period stepped abruptly");
	chk_wake_pass: assert property (@(posedge clk) disable iff (reset)
		(ce && st_reg == scs_pkg::SW_RUN && route_reg == scs_pkg::ROUTE_WAKE)
		|=> sys_clk_reg == $past(wake_reg))
		else $error("wakeup clock not routed");
	chk_no_glitch: assert property (@(posedge clk) disable iff (reset)
		$rose(sys_clk_reg) |-> $past(st_reg) == scs_pkg::SW_RUN)
		else $error("system clock rose during a switch");
endmodule

// File: scs_pkg.sv
// constants for the system clock source selector: register map, field layout,
// reset values, switch states and pll limits. assumes a 250 MHz fabric clock.
package scs_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam logic [4:0] ADDR_SYS_CFG = 5'h00;
	localparam logic [4:0] ADDR_PLL_CFG = 5'h04;
	localparam logic [4:0] ADDR_PRESC = 5'h08;
	localparam logic [4:0] ADDR_STATUS = 5'h0c;
	// source select codes
	localparam logic [1:0] SRC_WAKEUP = 2'h0;
	localparam logic [1:0] SRC_OSC = 2'h2;
	localparam logic [1:0] SRC_DIRECT = 2'h3;
	// internal route codes, index into the candidate clock vector
	localparam logic [1:0] ROUTE_WAKE = 2'h0;
	localparam logic [1:0] ROUTE_PRESC = 2'h1;
	localparam logic [1:0] ROUTE_PLL = 2'h2;
	localparam logic [1:0] ROUTE_DIRECT = 2'h3;
	// pll_config_reg layout
	localparam int unsigned PLL_BYPASS_BIT = 0;
	localparam int unsigned PLL_REFSEL_BIT = 1;
	localparam int unsigned PLL_BAND_LSB = 2;
	localparam int unsigned PLL_INPUT_DIV_FIELD_LSB = 4;
	localparam int unsigned PLL_FEEDBACK_MULT_FIELD_LSB = 8;
	localparam int unsigned PLL_OUTPUT_DIV_FIELD_LSB = 16;
	localparam int unsigned PLL_CFG_W = 23;
	localparam logic [22:0] PLL_CFG_RESET = 23'h000001;
	localparam logic [1:0] SYS_CFG_RESET = 2'h0;
	localparam logic [9:0] PRESC_RESET = 10'h000;
	// status layout: [1:0] active route, [2] switching, [3] locked, [4] vco in range
	localparam int unsigned STAT_SWITCH_BIT = 2;
	localparam int unsigned STAT_LOCK_BIT = 3;
	localparam int unsigned STAT_RANGE_BIT = 4;
	// vco bands in MHz, controlled mode
	localparam logic [7:0] BAND0_LO_MHZ = 8'h30;
	localparam logic [7:0] BAND0_HI_MHZ = 8'h70;
	localparam logic [7:0] BAND1_LO_MHZ = 8'h60;
	localparam logic [7:0] BAND1_HI_MHZ = 8'ha0;
	localparam logic [10:0] PRESC_MAX_FACTOR = 11'h400;
	localparam logic [15:0] PERIOD_RESET = 16'h0001;
	typedef enum logic [1:0] {
		SW_RUN = 2'b00,
		SW_DRAIN = 2'b01,
		SW_WAIT = 2'b11
	} scs_sw_type;
endpackage

// File: testbench.sv
// testbench for the system clock source selector: register access over axi4-lite
// and sys_clk period checks for each source and generation mode.
// assumes scs_pkg and scs_clock_select are compiled first; ce and wstrb held high.
`timescale 1ns/100ps
module testbench;
	logic clk, reset, ce, sys_clk;
	logic crystal_input_pin, onchip_clk_in, direct_clock_pin, wakeup_clk_in;
	logic [4:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] rd_data;
	logic last_clk = 1'b0;
	int fail_count = 0;
	int checks = 0;
	int tick = 0;
	int cycles = 0;
	int run_len = 0;
	int min_run = 1000;
	int per, hi;
	scs_clock_select scs_clock_select_inst (.clk(clk), .reset(reset), .ce(ce),
		.crystal_input_pin(crystal_input_pin), .onchip_clk_in(onchip_clk_in),
		.direct_clock_pin(direct_clock_pin), .wakeup_clk_in(wakeup_clk_in), .sys_clk(sys_clk),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// source pins: periods 10/16/6/20 cycles, uneven duty on crystal and direct
	always @(posedge clk) begin
		tick <= tick + 1;
		crystal_input_pin <= (tick % 10) < 3;
		onchip_clk_in <= (tick % 16) < 8;
		direct_clock_pin <= (tick % 6) < 2;
		wakeup_clk_in <= (tick % 20) < 10;
	end
	// shortest high or low run of sys_clk, in clk cycles
	always @(posedge clk) begin
		if (sys_clk === last_clk) begin
			run_len++;
		end else begin
			if (run_len < min_run) min_run = run_len;
			run_len = 1;
		end
		last_clk = sys_clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			fail_count++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (fail_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic cfg(input logic [4:0] a, input logic [31:0] d);
		wr(a, d, resp);
		chk("write response", 32'(resp), 32'h0);
	endtask
	task automatic meas();
		logic p;
		do begin p = sys_clk; @(posedge clk); end while (!(p === 1'b0 && sys_clk === 1'b1));
		per = 0;
		hi = 0;
		do begin
			p = sys_clk;
			@(posedge clk);
			per++;
			if (p === 1'b1) hi++;
		end while (!(p === 1'b0 && sys_clk === 1'b1));
	endtask
	// first period after a change may be partial, so the second one is kept
	task automatic settle();
		do rd(scs_pkg::ADDR_STATUS, rd_data, resp); while (rd_data[2] !== 1'b0);
		meas();
		meas();
	endtask
	task automatic t_reset();
		rd(scs_pkg::ADDR_SYS_CFG, rd_data, resp);
		chk("source reset", rd_data, 32'h0);
		rd(scs_pkg::ADDR_PLL_CFG, rd_data, resp);
		chk("pll cfg reset", rd_data, 32'h1);
		rd(scs_pkg::ADDR_PRESC, rd_data, resp);
		chk("presc reset", rd_data, 32'h0);
		rd(5'h10, rd_data, resp);
		chk("unmapped rresp", 32'(resp), 32'h2);
		wr(scs_pkg::ADDR_STATUS, 32'h0000_001f, resp);
		chk("status write bresp", 32'(resp), 32'h2);
		settle();
		chk("wakeup period", per, 20);
		chk("wakeup high", hi, 10);
		chk("route wake", 32'(rd_data[1:0]), 32'(scs_pkg::ROUTE_WAKE));
	endtask
	task automatic t_direct();
		min_run = 1000;
		cfg(scs_pkg::ADDR_SYS_CFG, 32'h3);
		settle();
		chk("direct period", per, 6);
		chk("direct high", hi, 2);
		chk("route direct", 32'(rd_data[1:0]), 32'(scs_pkg::ROUTE_DIRECT));
		chk("switch pulse", 32'(min_run >= 2), 32'h1);
	endtask
	task automatic t_presc();
		cfg(scs_pkg::ADDR_PLL_CFG, 32'h1);
		cfg(scs_pkg::ADDR_PRESC, 32'h2);
		min_run = 1000;
		cfg(scs_pkg::ADDR_SYS_CFG, 32'h2);
		settle();
		chk("presc 3 period", per, 30);
		chk("route presc", 32'(rd_data[1:0]), 32'(scs_pkg::ROUTE_PRESC));
		chk("switch pulse", 32'(min_run >= 2), 32'h1);
		cfg(scs_pkg::ADDR_PRESC, 32'h0);
		settle();
		chk("presc 1 period", per, 10);
		chk("presc 1 high", hi, 3);
		cfg(scs_pkg::ADDR_PLL_CFG, 32'h3);
		settle();
		chk("onchip ref period", per, 16);
		cfg(scs_pkg::ADDR_PLL_CFG, 32'h1);
		cfg(scs_pkg::ADDR_PRESC, 32'hffff_ffff);
		rd(scs_pkg::ADDR_PRESC, rd_data, resp);
		chk("presc max field", rd_data, 32'h3ff);
		settle();
		chk("presc 1024 period", per, 10240);
	endtask
	// on-chip reference 15.625 MHz; every setting used gives 62.5 MHz out
	task automatic pll_step(input logic [31:0] d, input logic in_band);
		int n;
		logic p;
		n = 0;
		cfg(scs_pkg::ADDR_PLL_CFG, d);
		do rd(scs_pkg::ADDR_STATUS, rd_data, resp);
		while (rd_data[3] !== 1'b1 || rd_data[2] !== 1'b0);
		repeat (300) @(posedge clk);
		repeat (160) begin
			p = sys_clk;
			@(posedge clk);
			if (p === 1'b0 && sys_clk === 1'b1) n++;
		end
		chk("pll edges", 32'(n >= 39 && n <= 41), 32'h1);
		rd(scs_pkg::ADDR_STATUS, rd_data, resp);
		chk("route pll", 32'(rd_data[1:0]), 32'(scs_pkg::ROUTE_PLL));
		chk("vco band", 32'(rd_data[4]), 32'(in_band));
	endtask
	task automatic t_pll();
		pll_step(32'h0000_0302, 1'b1);
		pll_step(32'h0000_0306, 1'b0);
		pll_step(32'h0001_0706, 1'b1);
	endtask
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		{crystal_input_pin, onchip_clk_in, direct_clock_pin, wakeup_clk_in} = 4'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_awaddr = 5'h00;
		s_axi_araddr = 5'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_direct();
		t_presc();
		t_pll();
		wrap_up();
	end
endmodule
